// [hdl/frame_pkg.sv]
/*
 package of constants for the host-side packet framer
 assumes a byte-wide serial transmitter and receiver outside this block
*/
package frame_pkg;
   // ------------------------------------------------------------
   // packet layout
   // ------------------------------------------------------------
   localparam int LEN_BYTES = 2;
   localparam int CRC_BYTES = 2;
   localparam logic [15:0] MIN_PACKET_LEN = 16'h0005;
   localparam logic [15:0] PACKET_OVERHEAD = 16'h0004;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam int FIFO_DEPTH = 16;
   // ------------------------------------------------------------
   // parameter field layouts
   // ------------------------------------------------------------
   localparam int SGL_SIGN_BIT = 31;
   localparam int SGL_EXP_MSB = 30;
   localparam int SGL_EXP_LSB = 23;
   localparam logic [7:0] SGL_EXP_MAX = 8'hFF;
   localparam logic [7:0] SGL_BIAS = 8'h7F;
   localparam int DBL_SIGN_BIT = 63;
   localparam int DBL_EXP_MSB = 62;
   localparam int DBL_EXP_LSB = 52;
   localparam logic [10:0] DBL_EXP_MAX = 11'h7FF;
   localparam logic [10:0] DBL_BIAS = 11'h3FF;
   localparam int SIGN_BIT32 = 31;
   localparam int SIGN_BIT16 = 15;
   localparam int SIGN_BIT8 = 7;
   localparam logic [7:0] BOOL_FALSE = 8'h00;
   localparam logic [7:0] BOOL_TRUE = 8'h01;
endpackage

// [hdl/byte_fifo.sv]
/*
 parameterised fifo with valid and ready on both sides
 assumes one clock and an asynchronous active-low reset
*/
`timescale 1ns/10ps
module byte_fifo
   import frame_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // handshake terms
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // no overflow past depth
   fifo_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
      count <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule // byte_fifo

// [hdl/host_framer.sv]
/*
 host-side packet framer and deframer for a compass serial protocol
 assumes byte streams to and from an outside uart on the same clock
*/
// Operation
// RQ1: length field counts whole packet bytes
// RQ2: checksum covers length through frame end
// RQ3: length and checksum sent high byte first
// RQ4: single floats use ieee 754 layout
// RQ5: double floats use ieee 754 layout
// RQ6: little-endian single float fully byte reversed
// RQ7: little-endian double reverses each half
// RQ8: signed 32-bit is two's complement
// RQ9: signed 16-bit is two's complement
// RQ10: signed 8-bit uses bit 7 sign
// RQ11: boolean is one byte, 0 or 1
// RQ12: frame starts with identifier; minimum five bytes
// RQ13: bad checksum or count drops packet
`timescale 1ns/10ps
module host_framer
   import frame_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // frame to send: identifier then payload bytes
   input wire logic [7:0] tx_in_data,
   input wire logic tx_in_valid,
   input wire logic tx_in_last,
   output logic tx_in_ready,
   // serial transmitter byte stream
   output logic [7:0] uart_tx_data,
   output logic uart_tx_valid,
   input wire logic uart_tx_ready,
   // serial receiver byte stream
   input wire logic [7:0] uart_rx_data,
   input wire logic uart_rx_valid,
   // received frame bytes: identifier then payload
   output logic [7:0] rx_out_data,
   output logic rx_out_valid,
   output logic rx_out_last,
   output logic rx_good,
   output logic rx_bad
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // one byte step of the checksum, msb first
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++)
      begin
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // transmit side: frame is collected in a buffer first
   // ------------------------------------------------------------
   logic [7:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;
   logic fifo_in_ready;
   logic [7:0] tx_buf [DEPTH];
   logic [4:0] tx_cnt;
   logic [4:0] tx_idx;
   logic [15:0] tx_crc;
   logic [15:0] tx_len;
   logic tx_have_last;

   typedef enum logic [4:0] {
      TX_FILL = 5'h01,
      TX_LEN_HI = 5'h02,
      TX_LEN_LO = 5'h04,
      TX_BODY = 5'h08,
      TX_CRC = 5'h10
   } tx_state_e;
   tx_state_e tx_state;
   logic tx_crc_lo;

   byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) in_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_data(tx_in_data),
      .in_valid(tx_in_valid && !tx_have_last),
      .in_ready(fifo_in_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );
   // stall the source while a packet is being sent
   assign tx_in_ready = fifo_in_ready && !tx_have_last;
   assign fifo_pop = (tx_state == TX_FILL) && fifo_valid
                     && (tx_cnt != 5'(DEPTH));

   // remembers that the frame end has entered the buffer
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_have_last <= 1'b0;
      end
      else if (tx_in_valid && tx_in_ready && tx_in_last)
      begin
         tx_have_last <= 1'b1;
      end
      else if (tx_state == TX_CRC && tx_crc_lo && uart_tx_ready)
      begin
         tx_have_last <= 1'b0;
      end
   end

   // drains the fifo into the frame buffer
   always_ff @(posedge clock)
   begin
      if (fifo_pop)
      begin
         // payload bytes pass unchanged, in the order the user gave them
         tx_buf[tx_cnt[3:0]] <= fifo_data; // RQ4 RQ5 RQ6 RQ7
      end
   end

   // transmit sequencer
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_state <= TX_FILL;
         tx_cnt <= '0;
         tx_idx <= '0;
         tx_crc <= CRC_INIT;
         tx_len <= '0;
         tx_crc_lo <= 1'b0;
         uart_tx_data <= '0;
         uart_tx_valid <= 1'b0;
      end
      else
      begin
         case (tx_state)
            TX_FILL:
            begin
               if (fifo_pop)
               begin
                  tx_cnt <= tx_cnt + 5'h01;
               end
               if (tx_have_last && !fifo_valid && tx_cnt != '0)
               begin
                  tx_len <= 16'(tx_cnt) + PACKET_OVERHEAD; // RQ1 RQ12
                  tx_state <= TX_LEN_HI;
               end
            end
            TX_LEN_HI:
            begin
               uart_tx_data <= tx_len[15:8]; // RQ3
               uart_tx_valid <= 1'b1;
               tx_crc <= crc_step(CRC_INIT, tx_len[15:8]); // RQ2
               tx_state <= TX_LEN_LO;
            end
            TX_LEN_LO:
            begin
               if (uart_tx_ready)
               begin
                  uart_tx_data <= tx_len[7:0];
                  tx_crc <= crc_step(tx_crc, tx_len[7:0]); // RQ2
                  tx_idx <= '0;
                  tx_state <= TX_BODY;
               end
            end
            TX_BODY:
            begin
               if (uart_tx_ready)
               begin
                  uart_tx_data <= tx_buf[tx_idx[3:0]];
                  tx_crc <= crc_step(tx_crc, tx_buf[tx_idx[3:0]]); // RQ2
                  tx_idx <= tx_idx + 5'h01;
                  if (tx_idx + 5'h01 == tx_cnt)
                  begin
                     tx_state <= TX_CRC;
                     tx_crc_lo <= 1'b0;
                  end
               end
            end
            TX_CRC:
            begin
               if (uart_tx_ready)
               begin
                  if (!tx_crc_lo)
                  begin
                     uart_tx_data <= tx_crc[15:8]; // RQ3
                     tx_crc_lo <= 1'b1;
                  end
                  else
                  begin
                     uart_tx_data <= tx_crc[7:0];
                     tx_crc_lo <= 1'b0;
                     tx_state <= TX_FILL;
                     tx_cnt <= '0;
                  end
               end
            end
            default:
            begin
               tx_state <= TX_FILL;
            end
         endcase
         if (tx_state == TX_FILL && uart_tx_ready)
         begin
            uart_tx_valid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // receive side: checked before release
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      RX_LEN_HI = 4'h1,
      RX_LEN_LO = 4'h2,
      RX_BODY = 4'h4,
      RX_CRC = 4'h8
   } rx_state_e;
   rx_state_e rx_state;
   logic [7:0] rx_buf [DEPTH];
   logic [15:0] rx_len;
   logic [15:0] rx_crc;
   logic [15:0] rx_got;
   logic [4:0] rx_cnt;
   logic [4:0] rx_out_idx;
   logic rx_crc_lo;
   logic rx_release;

   // gathers and checks one packet
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_state <= RX_LEN_HI;
         rx_len <= '0;
         rx_crc <= CRC_INIT;
         rx_got <= '0;
         rx_cnt <= '0;
         rx_crc_lo <= 1'b0;
         rx_good <= 1'b0;
         rx_bad <= 1'b0;
      end
      else
      begin
         rx_good <= 1'b0;
         rx_bad <= 1'b0;
         if (uart_rx_valid && !rx_release)
         begin
            case (rx_state)
               RX_LEN_HI:
               begin
                  rx_len[15:8] <= uart_rx_data; // RQ3
                  rx_crc <= crc_step(CRC_INIT, uart_rx_data); // RQ2
                  rx_cnt <= '0;
                  rx_state <= RX_LEN_LO;
               end
               RX_LEN_LO:
               begin
                  rx_len[7:0] <= uart_rx_data;
                  rx_crc <= crc_step(rx_crc, uart_rx_data);
                  // impossible count: resync on next field
                  if ({rx_len[15:8], uart_rx_data} < MIN_PACKET_LEN
                      || {rx_len[15:8], uart_rx_data}
                         > 16'(DEPTH) + PACKET_OVERHEAD)
                  begin
                     rx_bad <= 1'b1; // RQ13
                     rx_state <= RX_LEN_HI;
                  end
                  else
                  begin
                     rx_state <= RX_BODY;
                  end
               end
               RX_BODY:
               begin
                  // payload fields kept byte for byte, encoding untouched
                  rx_buf[rx_cnt[3:0]] <= uart_rx_data; // RQ8 RQ9 RQ10 RQ11
                  rx_crc <= crc_step(rx_crc, uart_rx_data); // RQ2
                  rx_cnt <= rx_cnt + 5'h01;
                  if (16'(rx_cnt) + 16'h0001 + PACKET_OVERHEAD == rx_len)
                  begin
                     rx_state <= RX_CRC;
                     rx_crc_lo <= 1'b0;
                  end
               end
               RX_CRC:
               begin
                  if (!rx_crc_lo)
                  begin
                     rx_got[15:8] <= uart_rx_data; // RQ3
                     rx_crc_lo <= 1'b1;
                  end
                  else
                  begin
                     rx_crc_lo <= 1'b0;
                     rx_state <= RX_LEN_HI;
                     if ({rx_got[15:8], uart_rx_data} == rx_crc)
                     begin
                        rx_good <= 1'b1;
                     end
                     else
                     begin
                        rx_bad <= 1'b1; // RQ13
                     end
                  end
               end
               default:
               begin
                  rx_state <= RX_LEN_HI;
               end
            endcase
         end
      end
   end

   // releases a good frame byte by byte
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_release <= 1'b0;
         rx_out_idx <= '0;
         rx_out_data <= '0;
         rx_out_valid <= 1'b0;
         rx_out_last <= 1'b0;
      end
      else
      begin
         rx_out_valid <= 1'b0;
         rx_out_last <= 1'b0;
         if (rx_good)
         begin
            rx_release <= 1'b1;
            rx_out_idx <= '0;
         end
         else if (rx_release)
         begin
            rx_out_data <= rx_buf[rx_out_idx[3:0]];
            rx_out_valid <= 1'b1;
            rx_out_last <= (rx_out_idx + 5'h01 == rx_cnt);
            rx_out_idx <= rx_out_idx + 5'h01;
            if (rx_out_idx + 5'h01 == rx_cnt)
            begin
               rx_release <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // length high byte follows a ready fill
   len_first_a: assert property (@(posedge clock) disable iff (!rst_n)
      tx_state == TX_LEN_HI |=> uart_tx_valid
         && uart_tx_data == tx_len[15:8]) // RQ3
      else $error("length high byte not sent first");
   // length covers frame plus four
   len_value_a: assert property (@(posedge clock) disable iff (!rst_n)
      tx_state == TX_LEN_HI |-> tx_len == 16'(tx_cnt) + 16'h0004) // RQ1
      else $error("length field wrong");
   // checksum starts from reset value over length
   crc_start_a: assert property (@(posedge clock) disable iff (!rst_n)
      tx_state == TX_LEN_HI |=> tx_crc == crc_step(CRC_INIT, tx_len[15:8]))
      else $error("checksum not seeded"); // RQ2
   // shortest packet is five bytes
   min_len_a: assert property (@(posedge clock) disable iff (!rst_n)
      tx_state == TX_LEN_LO |-> tx_len >= 16'h0005) // RQ12
      else $error("packet below five bytes");
   // good and bad never together
   rx_verdict_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(rx_good && rx_bad)) // RQ13
      else $error("good and bad together");
   // good packet releases its first byte two cycles later
   rx_release_a: assert property (@(posedge clock) disable iff (!rst_n)
      rx_good |=> ##1 rx_out_valid) // RQ13
      else $error("good frame not released");
endmodule // host_framer

// [dv/far_device.sv]
/*
 behavioural model of the compass module at the far end of the link
 assumes the host framer byte streams on the bench clock, no uart timing
*/
`timescale 1ns/10ps
module far_device
   import frame_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bytes from the host
   input wire logic [7:0] uart_tx_data,
   input wire logic uart_tx_valid,
   output logic uart_tx_ready,
   // bytes to the host
   output logic [7:0] uart_rx_data,
   output logic uart_rx_valid
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic slow;
   logic [7:0] got [$];
   logic [15:0] seen_len;
   int pkt_done;
   int bad_seen;

   // idle values at time zero
   initial
   begin
      slow = 1'b0;
      uart_rx_data = 8'h00;
      uart_rx_valid = 1'b0;
   end

   // checksum, msb first
   function automatic logic [15:0] crc_of(input logic [7:0] q [$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (q[i])
      begin
         c = c ^ {q[i], 8'h00};
         repeat (8) c = c[15] ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
      end
      return c;
   endfunction

   // accept every cycle, or every other cycle when slow
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         uart_tx_ready <= 1'b0;
      else
         uart_tx_ready <= slow ? ~uart_tx_ready : 1'b1;
   end

   // collect host packets and judge length and checksum
   always @(posedge clock)
   begin
      if (rst_n && uart_tx_valid && uart_tx_ready)
      begin
         got.push_back(uart_tx_data);
         seen_len = {got[0], got[1]};
         if (got.size() > 2 && got.size() == seen_len)
         begin
            if (seen_len < MIN_PACKET_LEN)
               bad_seen++;
            if (crc_of(got[0:got.size()-3]) !==
                {got[got.size()-2], got[got.size()-1]})
               bad_seen++;
            pkt_done++;
         end
      end
   end

   // send one packet, or only a forged length when len_ovr is set
   task automatic send_pkt(input logic [7:0] fr [$], input logic corrupt,
                           input logic [15:0] len_ovr);
      logic [7:0] p [$];
      logic [15:0] len;
      logic [15:0] c;
      len = (len_ovr != 16'h0000) ? len_ovr : 16'(fr.size() + 4);
      p = {len[15:8], len[7:0]};
      if (len_ovr == 16'h0000)
      begin
         p = {p, fr};
         c = crc_of(p) ^ {15'h0000, corrupt};
         p = {p, c[15:8], c[7:0]};
      end
      foreach (p[i])
      begin
         @(posedge clock);
         #1;
         uart_rx_data = p[i];
         uart_rx_valid = 1'b1;
         @(posedge clock);
         #1;
         uart_rx_valid = 1'b0;
         uart_rx_data = ~p[i];  // released line shows the inverse
      end
   endtask
endmodule // far_device

// [dv/tb.sv]
/*
 self-checking bench for the host framer
 assumes far_device on the serial side and one 8 ns clock
*/
`timescale 1ns/10ps
module tb;
   import frame_pkg::*;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic clock, rst_n, tx_in_valid, tx_in_last, tx_in_ready;
   logic [7:0] tx_in_data, uart_tx_data, uart_rx_data, rx_out_data;
   logic uart_tx_valid, uart_tx_ready, uart_rx_valid;
   logic rx_out_valid, rx_out_last, rx_good, rx_bad;
   int err_total, num_checks, good_cnt, bad_cnt, last_at;
   logic [7:0] rxq [$];
   logic [127:0] rows [5];
   int row_n [5] = '{1, 1, 5, 11, 16};
   logic [15:0] row_crc [5] = '{16'hEFD4, 16'hBF71, 16'h0000, 16'h0000,
                                16'h0000};

   host_framer #(.DEPTH(FIFO_DEPTH)) dut (
      .clock(clock), .rst_n(rst_n), .tx_in_data(tx_in_data),
      .tx_in_valid(tx_in_valid), .tx_in_last(tx_in_last),
      .tx_in_ready(tx_in_ready), .uart_tx_data(uart_tx_data),
      .uart_tx_valid(uart_tx_valid), .uart_tx_ready(uart_tx_ready),
      .uart_rx_data(uart_rx_data), .uart_rx_valid(uart_rx_valid),
      .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid),
      .rx_out_last(rx_out_last), .rx_good(rx_good), .rx_bad(rx_bad));
   far_device device (
      .clock(clock), .rst_n(rst_n), .uart_tx_data(uart_tx_data),
      .uart_tx_valid(uart_tx_valid), .uart_tx_ready(uart_tx_ready),
      .uart_rx_data(uart_rx_data), .uart_rx_valid(uart_rx_valid));

   // free-running clock
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // receive-side monitor
   always @(posedge clock)
   begin
      if (rx_good === 1'b1) good_cnt++;
      if (rx_bad === 1'b1) bad_cnt++;
      if (rx_out_valid === 1'b1) rxq.push_back(rx_out_data);
      if (rx_out_valid === 1'b1 && rx_out_last === 1'b1) last_at = rxq.size();
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input logic [15:0] seen, input logic [15:0] want);
      num_checks++;
      if (seen !== want)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task test_done;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   function int ev(input int sel);
      case (sel)
         0: return device.pkt_done;
         1: return good_cnt;
         default: return bad_cnt;
      endcase
   endfunction

   // bounded wait for an event count
   task wait_ev(input int sel, input int want);
      int g;
      for (g = 0; g < 600 && ev(sel) < want; g++) tick(1);
      if (ev(sel) < want)
      begin
         err_total++;
         test_done();
      end
   endtask

   // offer a frame, holding each byte until it is taken
   task send_tx(input logic [7:0] fr [$]);
      int g;
      foreach (fr[i])
      begin
         tx_in_data = fr[i];
         tx_in_last = (i == fr.size() - 1);
         tx_in_valid = 1'b1;
         for (g = 0; g < 600 && tx_in_ready !== 1'b1; g++) tick(1);
         if (tx_in_ready !== 1'b1)
         begin
            err_total++;
            test_done();
         end
         tick(1);
      end
      tx_in_valid = 1'b0;
      tx_in_last = 1'b0;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      logic [7:0] fr [$], pk [$];
      logic [15:0] len, want;
      logic [31:0] sgl;
      logic [63:0] dbl;
      int i, k, base;
      rst_n = 1'b0;
      tx_in_data = 8'h00;
      tx_in_valid = 1'b0;
      tx_in_last = 1'b0;
      sgl = {1'b0, SGL_BIAS, 23'h000000};
      dbl = {1'b0, DBL_BIAS, 52'h0};
      rows[0] = {8'h01, 120'h0};
      rows[1] = {8'h04, 120'h0};
      rows[2] = {8'h05, sgl[7:0], sgl[15:8], sgl[23:16], sgl[31:24],
                 88'h0};
      rows[3] = {8'h05, dbl[39:32], dbl[47:40], dbl[55:48], dbl[63:56],
                 dbl[7:0], dbl[15:8], dbl[23:16], dbl[31:24], BOOL_TRUE,
                 8'hFF, 40'h0};
      rows[4] = 128'h0E0F_1011_1213_1415_1617_1819_1A1B_1C1D;
      repeat (5) @(posedge clock);
      #1;
      check(uart_tx_valid, 16'h0000);
      check({rx_good, rx_bad, rx_out_valid}, 16'h0000);
      check(tx_in_ready, 16'h0001);
      rst_n = 1'b1;
      tick(2);
      // table of frames: out through the host, back through the device
      for (i = 0; i < 5; i++)
      begin
         fr = {};
         for (k = 0; k < row_n[i]; k++) fr.push_back(rows[i][127-8*k -: 8]);
         len = 16'(row_n[i] + 4);
         pk = {len[15:8], len[7:0], fr};
         want = (row_crc[i] != 16'h0000) ? row_crc[i] : device.crc_of(pk);
         device.slow = i[0];
         device.got = {};
         base = device.pkt_done;
         send_tx(fr);
         check(tx_in_ready, 16'h0000);
         wait_ev(0, base + 1);
         check(16'(device.got.size()), len);
         foreach (pk[k]) check(device.got[k], pk[k]);
         check({device.got[len-2], device.got[len-1]}, want);
         rxq = {};
         base = good_cnt;
         device.send_pkt(fr, 1'b0, 16'h0000);
         wait_ev(1, base + 1);
         tick(row_n[i] + 4);
         check(16'(rxq.size()), 16'(row_n[i]));
         foreach (fr[k]) check(rxq[k], fr[k]);
         check(16'(last_at), 16'(row_n[i]));
         tick(8);
      end
      // bad checksum, too short, too long; each followed by a good one
      fr = {8'h01};
      for (i = 0; i < 3; i++)
      begin
         base = bad_cnt;
         rxq = {};
         len = (i == 2) ? 16'(FIFO_DEPTH + 5) : 16'(i * 4);
         device.send_pkt(fr, i == 0, len);
         wait_ev(2, base + 1);
         tick(6);
         check(16'(rxq.size()), 16'h0000);
         base = good_cnt;
         device.send_pkt(fr, 1'b0, 16'h0000);
         wait_ev(1, base + 1);
         tick(8);
         check(rxq[0], 8'h01);
      end
      check(16'(device.bad_seen), 16'h0000);
      test_done();
   end
endmodule // tb
